// ### scm_pkg.sv
`default_nettype none
package scm_pkg;
  // register indices; byte address is four times the index, low 12 bits decoded
  localparam logic [31:0] SMR_IDX = 32'hffff_fe80;
  localparam logic [31:0] BRR_IDX = 32'hffff_fe82;
  localparam logic [31:0] SCR_IDX = 32'hffff_fe84;
  localparam logic [31:0] TDR_IDX = 32'hffff_fe86;
  localparam logic [31:0] SSR_IDX = 32'hffff_fe88;
  localparam logic [31:0] RDR_IDX = 32'hffff_fe8a;
  localparam logic [31:0] CMR_IDX = 32'hffff_fe8c;

  // serial mode fields
  localparam int SMR_CA = 7;
  localparam int SMR_ODD = 4;
  localparam int SMR_CKS = 0;
  // serial control fields
  localparam int SCR_TE = 5;
  localparam int SCR_RE = 4;
  localparam int SCR_CKE0 = 0;
  // status fields; bits 7..3 are the software-clearable flags
  localparam int SSR_FLAG_LSB = 3;
  localparam int F_TX_EMPTY_FLAG = 4;
  localparam int F_RX_FULL_FLAG = 3;
  localparam int F_OVERRUN_FLAG = 2;
  localparam int F_ERS = 1;
  localparam int F_PER = 0;
  localparam int SSR_TX_END_FLAG = 2;
  // card mode fields
  localparam int CMR_ORDER = 3;
  localparam int CMR_INV = 2;
  localparam int CMR_EN = 0;
  localparam logic [3:0] CMR_WMASK = 4'h d;

  // reset values
  localparam logic [7:0] BRR_RST = 8'hff;
  localparam logic [7:0] TDR_RST = 8'hff;
  localparam logic [7:0] SSR_RST = 8'h84;

  // timing: card clock is 372 per etu, one prescaler tick per card clock half
  localparam int ETU_CARD_CLKS = 372;
  localparam int TICKS_PER_CARD_CLK = 2;
  localparam int HALF_ETU_TICKS = ETU_CARD_CLKS * TICKS_PER_CARD_CLK / 2;
  // times in tenths of an etu, counted from the start bit
  localparam int FRAME_TETU = 100;
  localparam int ERR_START_TETU = 105;
  localparam int ERR_LEN_TETU = 10;
  localparam int RESEND_GAP_TETU = 20;
  localparam int TX_END_FLAG_CA0_TETU = 25;
  localparam int TX_END_FLAG_CA1_TETU = 10;
  // the same times in half etu
  localparam int HE_PAR_SAMPLE = FRAME_TETU / 5 - 2;
  localparam int HE_ERR_START = ERR_START_TETU / 5;
  localparam int HE_ERR_END = (ERR_START_TETU + ERR_LEN_TETU) / 5;
  localparam int HE_ERR_SAMPLE = (ERR_START_TETU + ERR_LEN_TETU / 2) / 5;
  localparam int HE_NEXT = HE_ERR_SAMPLE + RESEND_GAP_TETU / 5;
  localparam int HE_TX_END_FLAG_CA0 = (FRAME_TETU + TX_END_FLAG_CA0_TETU) / 5;
  localparam int HE_TX_END_FLAG_CA1 = (FRAME_TETU + TX_END_FLAG_CA1_TETU) / 5;

  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_RUN = 2'b01} scm_tx_t;
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_RUN = 2'b01, RX_ERR = 2'b11} scm_rx_t;
endpackage
`default_nettype wire

// ### scm_card_uart.sv
// Function
// - mode-select bit enables card mode, reset zero
// - direction bit picks LSB or MSB first
// - inversion bit inverts data both directions
// - parity bit level never inverted
// - reset and standby clear mode bits
// - reserved mode bits read fixed, unwritable
// - status bit4 sets on low error signal
// - error flag cleared by reset, standby, write0
// - clearing transmit enable keeps error flag
// - no framing check in card mode
// - tx_empty_flag clear or data write clears tx_end_flag
// - tx_end_flag set on reset, standby, te off while error flag clear
// - tx_end_flag 2.5 etu after character, mode0
// - tx_end_flag 1.0 etu after character, mode1
// - flags clear on written zero only
// - reset loads status, bit rate, data values
// - start bit, eight data, one parity
// - parity error drives line low 1 etu
// - resend after error, 2 etu gap
`timescale 1ns/1ps
`default_nettype none
module scm_card_uart #(
  parameter int HALF_ETU_TICKS = scm_pkg::HALF_ETU_TICKS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic standby,
  input wire logic serial_rx_in,
  output logic serial_tx_out,
  output logic card_clock_out
);
  import scm_pkg::*;

  localparam int PW = $clog2(HALF_ETU_TICKS + 1);

  typedef struct packed {
    logic [7:0] smr;
    logic [7:0] brr;
    logic [7:0] scr;
    logic [7:0] tdr;
    logic [7:0] rdr;
    logic [3:0] cmr;
    logic [4:0] flg;
    logic [4:0] seen;
    logic tx_end_flag;
    logic mpbt;
    logic [14:0] pre;
    logic [PW-1:0] tx_ph;
    logic [PW-1:0] rx_ph;
    scm_tx_t tx_st;
    logic [4:0] tx_h;
    logic tx_err;
    logic [7:0] tsr;
    scm_rx_t rx_st;
    logic [4:0] rx_h;
    logic rx_par;
    logic [7:0] rsr;
    logic [1:0] rsync;
    logic rx_prev;
    logic txd;
    logic sck;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } scm_state_t;

  scm_state_t s;
  scm_state_t next_s;

  function automatic logic hit(input logic [31:0] a, input logic [31:0] idx);
    return (a[11:2] == idx[9:0]) && (a[1:0] == 2'b00);
  endfunction

  // level that the transmitter puts on the line in a given state
  function automatic logic tx_line(input scm_state_t t);
    logic [3:0] k;
    logic b;
    k = t.tx_h[4:1];
    b = 1'b1;
    if (t.tx_st == TX_RUN) begin
      if (k == 4'd0) begin
        b = 1'b0;
      end else if (k <= 4'd8) begin
        b = (t.cmr[CMR_ORDER] ? t.tsr[3'(4'd8 - k)] : t.tsr[3'(k - 4'd1)])
            ^ t.cmr[CMR_INV];
      end else if (k == 4'd9) begin
        b = ^t.tsr ^ t.smr[SMR_ODD];
      end
    end
    return b;
  endfunction

  logic setup, acc, wr, rd, en, te, re, tick, tx_half, rx_half, rxs, fall;
  logic smp_low, tx_end_flag_set, mapped;
  logic [14:0] div;
  logic [7:0] rdata;

  always_comb begin
    next_s = s;
    setup = psel & ~penable;
    acc = psel & penable & s.pready;
    wr = acc & pwrite;
    rd = acc & ~pwrite;
    en = s.cmr[CMR_EN];
    te = s.scr[SCR_TE];
    re = s.scr[SCR_RE];
    smp_low = 1'b0;
    tx_end_flag_set = 1'b0;

    // prescaler: one tick per half card clock
    div = (15'(s.brr) + 15'd1) << {s.smr[SMR_CKS + 1], s.smr[SMR_CKS], 1'b0};
    // compare with >= so a smaller divider written mid-count cannot stall ticks
    tick = (s.pre >= div - 15'd1);
    next_s.pre = tick ? 15'd0 : s.pre + 15'd1;
    tx_half = tick && (s.tx_ph == PW'(HALF_ETU_TICKS - 1));
    rx_half = tick && (s.rx_ph == PW'(HALF_ETU_TICKS - 1));
    if (tick) begin
      next_s.tx_ph = tx_half ? '0 : s.tx_ph + PW'(1);
      next_s.rx_ph = rx_half ? '0 : s.rx_ph + PW'(1);
    end
    next_s.sck = (en && s.scr[SCR_CKE0]) ? (s.sck ^ tick) : 1'b0;

    next_s.rsync = {s.rsync[0], serial_rx_in};
    rxs = s.rsync[1];
    next_s.rx_prev = rxs;
    fall = s.rx_prev & ~rxs;

    // register read mux
    rdata = 8'h00;
    mapped = 1'b1;
    if (hit(paddr, SMR_IDX)) begin
      rdata = s.smr;
    end else if (hit(paddr, BRR_IDX)) begin
      rdata = s.brr;
    end else if (hit(paddr, SCR_IDX)) begin
      rdata = s.scr;
    end else if (hit(paddr, TDR_IDX)) begin
      rdata = s.tdr;
    end else if (hit(paddr, SSR_IDX)) begin
      rdata = {s.flg, s.tx_end_flag, 1'b0, s.mpbt};
    end else if (hit(paddr, RDR_IDX)) begin
      rdata = s.rdr;
    end else if (hit(paddr, CMR_IDX)) begin
      rdata = {4'h0, s.cmr};
    end else begin
      mapped = 1'b0;
    end
    next_s.pready = setup;
    next_s.pslverr = setup & ~mapped;
    if (setup) begin
      next_s.prdata = {24'h00_0000, rdata};
    end

    if (rd && hit(paddr, SSR_IDX)) begin
      next_s.seen = s.seen | s.flg;
    end
    if (wr) begin
      if (hit(paddr, SMR_IDX)) begin
        next_s.smr = pwdata[7:0];
      end
      if (hit(paddr, BRR_IDX)) begin
        next_s.brr = pwdata[7:0];
      end
      if (hit(paddr, SCR_IDX)) begin
        next_s.scr = pwdata[7:0];
      end
      if (hit(paddr, TDR_IDX)) begin
        next_s.tdr = pwdata[7:0];
        next_s.tx_end_flag = 1'b0;
      end
      if (hit(paddr, SSR_IDX)) begin
        for (int i = 0; i < 5; i++) begin
          if (!pwdata[i + SSR_FLAG_LSB] && s.seen[i]) begin
            next_s.flg[i] = 1'b0;
          end
        end
        if (!pwdata[F_TX_EMPTY_FLAG + SSR_FLAG_LSB] && s.seen[F_TX_EMPTY_FLAG]) begin
          next_s.tx_end_flag = 1'b0;
        end
        next_s.mpbt = pwdata[0];
        next_s.seen = 5'b0_0000;
      end
      if (hit(paddr, CMR_IDX)) begin
        next_s.cmr = pwdata[3:0] & CMR_WMASK;
      end
    end

    // transmitter
    if (!te || !en) begin
      next_s.tx_st = TX_IDLE;
      next_s.tx_h = 5'd0;
      next_s.tx_err = 1'b0;
    end else begin
      case (s.tx_st)
        TX_IDLE: begin
          if (!s.flg[F_TX_EMPTY_FLAG] && s.rx_st == RX_IDLE) begin
            next_s.tsr = s.tdr;
            next_s.flg[F_TX_EMPTY_FLAG] = 1'b1;
            next_s.tx_st = TX_RUN;
            next_s.tx_h = 5'd0;
            next_s.tx_ph = '0;
          end
        end
        TX_RUN: begin
          if (tx_half) begin
            next_s.tx_h = s.tx_h + 5'd1;
            if (s.tx_h == 5'(HE_ERR_SAMPLE - 1) && !rxs) begin
              next_s.tx_err = 1'b1;
              smp_low = 1'b1;
            end
            if (s.tx_h == 5'((s.smr[SMR_CA] ? HE_TX_END_FLAG_CA1 : HE_TX_END_FLAG_CA0) - 1)) begin
              tx_end_flag_set = !s.tx_err && !smp_low && s.flg[F_TX_EMPTY_FLAG]
                         && !s.flg[F_ERS];
            end
            if (s.tx_h == 5'(HE_NEXT - 1)) begin
              next_s.tx_h = 5'd0;
              next_s.tx_err = 1'b0;
              if (!s.tx_err) begin
                next_s.tx_st = TX_IDLE;
              end
              // else stays in TX_RUN and resends tsr
            end
          end
        end
        default: next_s.tx_st = TX_IDLE;
      endcase
    end

    // receiver
    if (!re || !en) begin
      next_s.rx_st = RX_IDLE;
    end else begin
      case (s.rx_st)
        RX_IDLE: begin
          if (fall && s.tx_st == TX_IDLE) begin
            next_s.rx_st = RX_RUN;
            next_s.rx_h = 5'd0;
            next_s.rx_ph = '0;
            next_s.rx_par = 1'b0;
          end
        end
        RX_RUN: begin
          if (rx_half) begin
            next_s.rx_h = s.rx_h + 5'd1;
            if (!s.rx_h[0]) begin
              if (s.rx_h == 5'd0) begin
                if (rxs) begin
                  next_s.rx_st = RX_IDLE;
                end
              end else if (s.rx_h < 5'(HE_PAR_SAMPLE)) begin
                next_s.rsr = s.cmr[CMR_ORDER] ? {s.rsr[6:0], rxs}
                                              : {rxs, s.rsr[7:1]};
                next_s.rx_par = s.rx_par ^ rxs;
              end else if ((s.rx_par ^ rxs) == s.smr[SMR_ODD]) begin
                next_s.rx_st = RX_IDLE;
                if (s.flg[F_RX_FULL_FLAG]) begin
                  next_s.flg[F_OVERRUN_FLAG] = 1'b1;
                end else begin
                  next_s.rdr = s.rsr ^ {8{s.cmr[CMR_INV]}};
                  next_s.flg[F_RX_FULL_FLAG] = 1'b1;
                end
              end else begin
                next_s.flg[F_PER] = 1'b1;
                next_s.rx_st = RX_ERR;
              end
            end
          end
        end
        RX_ERR: begin
          if (rx_half) begin
            next_s.rx_h = s.rx_h + 5'd1;
            if (s.rx_h == 5'(HE_ERR_END - 1)) begin
              next_s.rx_st = RX_IDLE;
            end
          end
        end
        default: next_s.rx_st = RX_IDLE;
      endcase
    end

    // hardware sets after software clears
    if (smp_low) begin
      next_s.flg[F_ERS] = 1'b1;
    end
    if (tx_end_flag_set || (!te && !s.flg[F_ERS])) begin
      next_s.tx_end_flag = 1'b1;
    end
    if (standby) begin
      next_s.cmr = s.cmr & ~CMR_WMASK;
      next_s.flg[F_ERS] = 1'b0;
      next_s.tx_end_flag = 1'b1;
      next_s.tx_st = TX_IDLE;
      next_s.tx_err = 1'b0;
      next_s.rx_st = RX_IDLE;
    end

    next_s.txd = tx_line(next_s)
                 & ~(next_s.rx_st == RX_ERR && next_s.rx_h >= 5'(HE_ERR_START));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.brr <= BRR_RST;
      s.tdr <= TDR_RST;
      s.flg <= SSR_RST[7:SSR_FLAG_LSB];
      s.tx_end_flag <= SSR_RST[SSR_TX_END_FLAG];
      s.txd <= 1'b1;
      s.rsync <= 2'b11;
      s.rx_prev <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign serial_tx_out = s.txd;
  assign card_clock_out = s.sck;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence tdr_wr_s;
    psel && penable && pready && pwrite && hit(paddr, TDR_IDX);
  endsequence
  sequence tx_start_s;
    s.tx_st == TX_IDLE ##1 (s.tx_st == TX_RUN && s.tx_h == 5'd0 && !$past(s.tx_err));
  endsequence

  mode_off_idle_a: assert property ((!s.cmr[CMR_EN]) [*2] |-> s.tx_st == TX_IDLE && serial_tx_out)
    else $error("transmitter active with card mode off");
  start_bit_a: assert property (tx_start_s |-> !serial_tx_out && s.flg[F_TX_EMPTY_FLAG])
    else $error("frame did not begin with low start bit");
  first_bit_a: assert property (s.tx_st == TX_RUN && s.tx_h[4:1] == 4'd1 |-> serial_tx_out == ((s.cmr[CMR_ORDER] ? s.tsr[7] : s.tsr[0]) ^ s.cmr[CMR_INV]))
    else $error("first data bit has wrong order or polarity");
  parity_level_a: assert property (s.tx_st == TX_RUN && s.tx_h[4:1] == 4'd9 |-> serial_tx_out == (^s.tsr ^ s.smr[SMR_ODD]))
    else $error("parity bit level wrong");
  ers_hold_a: assert property (s.flg[F_ERS] && !standby && !(wr && hit(paddr, SSR_IDX) && !pwdata[F_ERS + SSR_FLAG_LSB]) |=> s.flg[F_ERS])
    else $error("error flag lost without a clearing write");
  ers_one_write_a: assert property (wr && hit(paddr, SSR_IDX) && pwdata[F_ERS + SSR_FLAG_LSB] && s.flg[F_ERS] && !standby |=> s.flg[F_ERS])
    else $error("writing one cleared the error flag");
  tx_end_flag_te_off_a: assert property (!s.scr[SCR_TE] && !s.flg[F_ERS] |=> s.tx_end_flag)
    else $error("end flag not set with transmitter off");
  tx_end_flag_tdr_clr_a: assert property ((s.scr[SCR_TE] && s.tx_st == TX_IDLE && !standby) and tdr_wr_s |=> !s.tx_end_flag)
    else $error("data write did not clear end flag");
  tx_end_flag_late_a: assert property (s.tx_st == TX_RUN && tx_half && s.tx_h == 5'(HE_TX_END_FLAG_CA0 - 1) && !s.smr[SMR_CA] && !s.tx_err && s.flg[F_TX_EMPTY_FLAG] && !s.flg[F_ERS] && s.scr[SCR_TE] && s.cmr[CMR_EN] |=> s.tx_end_flag)
    else $error("end flag not set 2.5 etu after character");
  err_drive_a: assert property (s.rx_st == RX_ERR && s.rx_h >= 5'(HE_ERR_START) |-> !serial_tx_out)
    else $error("error signal not driven low");
  resend_a: assert property (s.tx_st == TX_RUN && tx_half && s.tx_err && s.tx_h == 5'(HE_NEXT - 1) && s.scr[SCR_TE] && s.cmr[CMR_EN] && !standby |=> s.tx_st == TX_RUN && s.tx_h == 5'd0 && $stable(s.tsr))
    else $error("character not resent after error signal");
  cmr_rsvd_a: assert property (s.cmr[1] == 1'b0)
    else $error("reserved mode bit became set");
  standby_clear_a: assert property (standby |=> !s.flg[F_ERS] && s.tx_end_flag && s.cmr == 4'h0)
    else $error("standby did not clear mode bits and error flag");
  clock_off_a: assert property (!s.cmr[CMR_EN] |=> !card_clock_out)
    else $error("card clock running with card mode off");
endmodule
`default_nettype wire

// ### scm_card_model.sv
`timescale 1ns/1ps
`default_nettype none
module scm_card_model #(
  parameter int ETU = 64
) (
  input wire logic pclk,
  input wire logic line,
  output logic drv_n
);
  logic [8:0] rx_bits;
  int rx_frames = 0;
  int errs_left = 0;
  logic busy = 1'b0;
  logic saw_err = 1'b0;
  time t_start = 0;
  time t_prev = 0;

  task automatic he(input int n);
    repeat (n * ETU / 2) @(posedge pclk);
  endtask

  // receive a device frame; optionally answer with an error signal
  initial begin
    drv_n = 1'b1;
    forever begin
      @(negedge line);
      if (!busy) begin
        t_prev = t_start;
        t_start = $time;
        he(1);
        for (int i = 0; i < 9; i++) begin
          he(2);
          rx_bits[i] = line;
        end
        if (errs_left > 0) begin
          errs_left--;
          he(2);
          drv_n <= 1'b0;
          he(2);
          drv_n <= 1'b1;
        end
        rx_frames++;
      end
    end
  end

  // send one frame, look for an error signal, then keep the guard time
  task automatic send(input logic [8:0] bits);
    busy = 1'b1;
    drv_n <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      he(2);
      drv_n <= (i < 9) ? bits[i] : 1'b1;
    end
    he(2);
    saw_err = !line;
    he(2);
    busy = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### scm_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import scm_pkg::*;
  localparam int HE = 4;
  localparam int ETU = 64;
  localparam int LIMIT = 40000;
  logic pclk, presetn, psel, penable, pwrite, standby, tx_out, drv_n, pready, pslverr, e, sck;
  logic [31:0] paddr, pwdata, prdata, v;
  logic [8:0] f, g;
  logic [7:0] d;
  logic ord, inv, odd, ca;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int n;
  time t0;
  logic [31:0] idx_tab [7] = '{SMR_IDX, BRR_IDX, SCR_IDX, TDR_IDX, SSR_IDX, RDR_IDX, CMR_IDX};
  logic [7:0] rst_tab [7] = '{8'h00, 8'hff, 8'h00, 8'hff, 8'h84, 8'h00, 8'h00};
  // pull-up: released line reads high
  wire line = tx_out & drv_n;

  scm_card_uart #(.HALF_ETU_TICKS(HE)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .standby(standby), .serial_rx_in(line), .serial_tx_out(tx_out), .card_clock_out(sck));
  scm_card_model #(.ETU(ETU)) card_u (.pclk(pclk), .line(line), .drv_n(drv_n));

  function automatic logic [8:0] frame(logic [7:0] x, logic o, logic iv, logic od);
    logic [7:0] y;
    for (int i = 0; i < 8; i++) y[i] = o ? x[7 - i] : x[i];
    y = iv ? ~y : y;
    return {^y ^ od, y};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [31:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= idx << 2;
    pwdata <= 32'(wd);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] idx, input logic [7:0] wd);
    logic [31:0] x;
    logic r;
    apb(1'b1, idx, wd, x, r);
  endtask

  task automatic rd(input logic [31:0] idx, output logic [31:0] x);
    logic r;
    apb(1'b0, idx, 8'h00, x, r);
  endtask

  task automatic kick(input logic [7:0] x);
    wr(TDR_IDX, x);
    rd(SSR_IDX, v);
    chk(32'(v[SSR_TX_END_FLAG]), 0);
    wr(SSR_IDX, 8'h7f);
  endtask

  task automatic wait_frames(input int k);
    int goal;
    goal = card_u.rx_frames + k;
    while (card_u.rx_frames < goal) @(posedge pclk);
  endtask

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors++;
      results();
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    standby = 1'b0;
    n = $urandom(32'h0000_378c);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (idx_tab[i]) begin
      rd(idx_tab[i], v);
      chk(v, 32'(rst_tab[i]));
    end
    apb(1'b0, 32'h0000_0281, 8'h00, v, e);
    chk({v[30:0], e}, 1);
    wr(CMR_IDX, 8'hff);
    rd(CMR_IDX, v);
    chk(v, 32'h0000_000d);
    $display("registers done");
    wr(BRR_IDX, 8'h07);
    wr(SCR_IDX, 8'h31);
    for (int c = 0; c < 2; c++) begin
      wr(SMR_IDX, 8'(c));
      @(posedge sck);
      t0 = $time;
      @(posedge sck);
      chk(32'($time - t0), 32'(64 << (2 * c)));
    end
    $display("card clock done");
    for (int k = 0; k < 4; k++) begin
      {ord, inv} = 2'(k);
      ca = k[0] ^ k[1];
      odd = 1'($urandom);
      d = 8'($urandom);
      wr(SMR_IDX, {ca, 2'b00, odd, 4'h0});
      wr(CMR_IDX, {4'h0, ord, inv, 2'b01});
      kick(d);
      wait_frames(1);
      chk(32'(card_u.rx_bits), 32'(frame(d, ord, inv, odd)));
      t0 = card_u.t_start;
      v = '0;
      while (v[SSR_TX_END_FLAG] !== 1'b1) rd(SSR_IDX, v);
      n = int'(($time - t0) / 4) - (ca ? 22 : 25) * ETU / 2;
      chk(32'(n >= -8 && n <= 24), 1);
    end
    $display("transmit done");
    card_u.errs_left = 1;
    kick(d);
    wait_frames(2);
    chk(32'(card_u.rx_bits), 32'(frame(d, ord, inv, odd)));
    chk(32'(card_u.t_start - card_u.t_prev >= 13 * ETU * 4 - 32), 1);
    repeat (4 * ETU) @(posedge pclk);
    rd(SSR_IDX, v);
    chk(32'({v[4], v[SSR_TX_END_FLAG]}), 2);
    wr(SCR_IDX, 8'h11);
    rd(SSR_IDX, v);
    chk(32'({v[4], v[SSR_TX_END_FLAG]}), 2);
    wr(SSR_IDX, 8'hff);
    rd(SSR_IDX, v);
    chk(32'(v[4]), 1);
    wr(SSR_IDX, 8'hef);
    rd(SSR_IDX, v);
    chk(32'({v[4], v[SSR_TX_END_FLAG]}), 1);
    wr(SCR_IDX, 8'h31);
    $display("error resend done");
    for (int k = 0; k < 4; k++) begin
      {ord, inv} = 2'($urandom);
      d = (k == 0) ? 8'h00 : 8'($urandom);
      wr(CMR_IDX, {4'h0, ord, inv, 2'b01});
      f = frame(d, 1'b0, 1'b0, odd);
      f[8] = f[8] ^ k[0];
      g = frame(f[7:0], ord, inv, odd);
      card_u.send(f);
      chk(32'(card_u.saw_err), 32'(k[0]));
      rd(SSR_IDX, v);
      chk(32'(v[6:3]), k[0] ? 1 : 8);
      rd(RDR_IDX, v);
      if (!k[0]) chk(v, 32'(g[7:0]));
      wr(SSR_IDX, 8'hb7);
    end
    $display("receive done");
    wr(CMR_IDX, 8'h0d);
    wr(TDR_IDX, 8'h5a);
    @(posedge pclk);
    standby <= 1'b1;
    @(posedge pclk);
    standby <= 1'b0;
    rd(CMR_IDX, v);
    chk(v, 0);
    chk(32'(sck), 0);
    rd(SSR_IDX, v);
    chk(32'(v[SSR_TX_END_FLAG]), 1);
    n = card_u.rx_frames;
    kick(8'h5a);
    repeat (16 * ETU) @(posedge pclk);
    chk(32'(card_u.rx_frames - n), 0);
    wr(CMR_IDX, 8'h01);
    wait_frames(1);
    chk(32'(card_u.rx_bits), 32'(frame(8'h5a, 1'b0, 1'b0, odd)));
    $display("standby and enable done");
    results();
  end
endmodule
`default_nettype wire
